/* File: design/io_port_pkg.sv */
// Constants for the four-port I/O block: register offsets inside the
// I/O register space, widths and port sizes.
// Assumes the microcontroller decodes the I/O register space base itself.
package io_port_pkg;
	localparam int DATA_W = 8;
	localparam int PORT_D_W = 3;
	localparam int CELL_W = 16;
	localparam int ICELL_W = 24;
	localparam int ADDR_W = 5;
	// Register offsets within the I/O register space
	localparam logic [4:0] PIN_IN_A = 5'h00;
	localparam logic [4:0] PIN_IN_B = 5'h01;
	localparam logic [4:0] PIN_IN_C = 5'h02;
	localparam logic [4:0] PIN_IN_D = 5'h03;
	localparam logic [4:0] PIN_OUT_A = 5'h04;
	localparam logic [4:0] PIN_OUT_B = 5'h05;
	localparam logic [4:0] PIN_OUT_C = 5'h06;
	localparam logic [4:0] PIN_OUT_D = 5'h07;
	localparam logic [4:0] OCELL_A = 5'h08;
	localparam logic [4:0] OCELL_B = 5'h09;
	localparam logic [4:0] OCELL_C = 5'h0a;
	localparam logic [4:0] OBLOCK_A = 5'h0c;
	localparam logic [4:0] OBLOCK_B = 5'h0d;
	localparam logic [4:0] OBLOCK_C = 5'h0e;
	localparam logic [4:0] ICELL_A = 5'h10;
	localparam logic [4:0] ICELL_B = 5'h11;
	localparam logic [4:0] ICELL_C = 5'h12;
	localparam logic [4:0] DRV_EN_A = 5'h14;
	localparam logic [4:0] DRV_EN_B = 5'h15;
	localparam logic [4:0] DRV_EN_C = 5'h16;
	// Reset values
	localparam logic [7:0] BLOCK_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// Port A/B pins that may be open drain start here
	localparam int OD_LOW_BIT = 4;
	localparam int SLEW_W = 4;
endpackage

/* File: design/io_port_macrocell_access.sv */
// Four-port I/O block: port data registers, output and input logic cells,
// pin drivers, external selects and the chip-select input.
// Assumes a synchronous microcontroller register port on ref_clk and
// configuration bits supplied by a separate configuration block.
`timescale 1ns/1ps
`default_nettype none
module io_port_macrocell_access
	import io_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic io_register_space,
	input wire logic [4:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe,
	input wire logic [2:0] port_d_in,
	output logic [2:0] port_d_out,
	output logic [2:0] port_d_oe,
	input wire logic [7:0] dir_a,
	input wire logic [7:0] dir_b,
	input wire logic [7:0] dir_c,
	input wire logic [2:0] dir_d,
	input wire logic [7:0] drive_a,
	input wire logic [7:0] drive_b,
	input wire logic [7:0] drive_c,
	input wire logic [2:0] drive_d,
	input wire logic [7:0] oe_term_a,
	input wire logic [7:0] oe_term_b,
	input wire logic [7:0] oe_term_c,
	input wire logic [7:0] cell_on_a,
	input wire logic [7:0] cell_on_b,
	input wire logic [7:0] cell_on_c,
	input wire logic b_uses_second_group,
	input wire logic [15:0] cell_d_in,
	input wire logic [23:0] icell_store_mode,
	input wire logic data_port_mode,
	input wire logic periph_mode,
	input wire logic periph_sel,
	input wire logic dbe_select,
	input wire logic battery_on_select,
	input wire logic battery_low,
	input wire logic [2:0] ecs_enable,
	input wire logic [2:0] ecs_term,
	input wire logic [2:0] ecs_active_low,
	input wire logic [2:0] ecs_oe_term,
	input wire logic [2:0] ecs_oe_from_term,
	input wire logic [2:0] d_dedicated,
	output logic [23:0] input_logic_cell,
	output logic [2:0] d_direct,
	output logic [15:0] output_logic_cell,
	output logic address_strobe_in,
	output logic data_byte_enable,
	output logic memories_disable,
	output logic [3:0] fast_slew_a,
	output logic [3:0] fast_slew_b,
	output logic [2:0] fast_slew_d
);
	// ****************************************
	// Helper functions
	// ****************************************
	// Write hit on one register offset
	function automatic logic wr_hit(input logic en, input logic [4:0] a, input logic [4:0] o);
		wr_hit = en && (a == o);
	endfunction
	// Open-drain driver: drive only low, release for high; returns {out, oe}
	function automatic logic [1:0] drv(input logic val, input logic oe, input logic od);
		drv = od ? {1'b0, oe & ~val} : {val, oe};
	endfunction

	// ****************************************
	// Pin synchronisers and logic clock edge
	// ****************************************
	logic [27:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
	logic lclk_old_reg, lclk_old_next;
	logic [27:0] pin_s;
	logic lclk_rise, csi_block, acc_wr, acc_rd;
	assign pin_s = sync2_reg;
	assign lclk_rise = pin_s[25] && !lclk_old_reg && d_dedicated[1];
	assign csi_block = pin_s[26] && d_dedicated[2];
	assign acc_wr = clk_en && io_register_space && bus_wr && !csi_block;
	assign acc_rd = clk_en && io_register_space && bus_rd && !csi_block;
	// Next values of the synchroniser chain
	always_comb begin
		sync1_next = {battery_low, port_d_in, port_c_in, port_b_in, port_a_in};
		sync2_next = sync1_reg;
		lclk_old_next = pin_s[25];
	end
	// Synchroniser registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 28'h0000000;
			sync2_reg <= 28'h0000000;
			lclk_old_reg <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			lclk_old_reg <= lclk_old_next;
		end
	end

	// ****************************************
	// Register file and logic cells
	// ****************************************
	logic [7:0] out_a_reg, out_b_reg, out_c_reg, out_a_next, out_b_next, out_c_next;
	logic [2:0] out_d_reg, out_d_next;
	logic [7:0] blk_a_reg, blk_b_reg, blk_c_reg, blk_a_next, blk_b_next, blk_c_next;
	logic [15:0] cell_reg, cell_next;
	logic [23:0] icell_reg, icell_next;
	logic [7:0] rdata_reg, rdata_next, cell_b_view;
	assign cell_b_view = b_uses_second_group ? cell_reg[15:8] : cell_reg[7:0];
	// Bus writes, cell loading and read mux
	always_comb begin
		out_a_next = out_a_reg;
		out_b_next = out_b_reg;
		out_c_next = out_c_reg;
		out_d_next = out_d_reg;
		blk_a_next = blk_a_reg;
		blk_b_next = blk_b_reg;
		blk_c_next = blk_c_reg;
		cell_next = cell_reg;
		rdata_next = rdata_reg;
		// cells load on logic clock edge
		if (lclk_rise)
			cell_next = cell_d_in;
		if (wr_hit(acc_wr, bus_addr, PIN_OUT_A)) out_a_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, PIN_OUT_B)) out_b_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, PIN_OUT_C)) out_c_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, PIN_OUT_D)) out_d_next = bus_wdata[2:0];
		if (wr_hit(acc_wr, bus_addr, OBLOCK_A)) blk_a_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, OBLOCK_B)) blk_b_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, OBLOCK_C)) blk_c_next = bus_wdata;
		if (wr_hit(acc_wr, bus_addr, OCELL_A))
			cell_next[7:0] = (cell_next[7:0] & blk_a_reg) | (bus_wdata & ~blk_a_reg);
		if (wr_hit(acc_wr, bus_addr, OCELL_C))
			cell_next[15:8] = (cell_next[15:8] & blk_c_reg) | (bus_wdata & ~blk_c_reg);
		// port B reaches the group it carries
		if (wr_hit(acc_wr, bus_addr, OCELL_B)) begin
			if (b_uses_second_group)
				cell_next[15:8] = (cell_next[15:8] & blk_b_reg) | (bus_wdata & ~blk_b_reg);
			else
				cell_next[7:0] = (cell_next[7:0] & blk_b_reg) | (bus_wdata & ~blk_b_reg);
		end
		if (acc_rd) begin
			case (bus_addr)
				PIN_IN_A: rdata_next = pin_s[7:0];
				PIN_IN_B: rdata_next = pin_s[15:8];
				PIN_IN_C: rdata_next = pin_s[23:16];
				PIN_IN_D: rdata_next = {5'h00, pin_s[26:24]};
				PIN_OUT_A: rdata_next = out_a_reg;
				PIN_OUT_B: rdata_next = out_b_reg;
				PIN_OUT_C: rdata_next = out_c_reg;
				PIN_OUT_D: rdata_next = {5'h00, out_d_reg};
				OCELL_A: rdata_next = cell_reg[7:0];
				OCELL_B: rdata_next = cell_b_view;
				OCELL_C: rdata_next = cell_reg[15:8];
				OBLOCK_A: rdata_next = blk_a_reg;
				OBLOCK_B: rdata_next = blk_b_reg;
				OBLOCK_C: rdata_next = blk_c_reg;
				ICELL_A: rdata_next = icell_reg[7:0];
				ICELL_B: rdata_next = icell_reg[15:8];
				ICELL_C: rdata_next = icell_reg[23:16];
				DRV_EN_A: rdata_next = port_a_oe;
				DRV_EN_B: rdata_next = port_b_oe;
				DRV_EN_C: rdata_next = port_c_oe;
				default: rdata_next = UNMAPPED_RD;
			endcase
		end
	end
	// Input cells: store on clock edge or pass while logic clock high
	always_comb begin
		icell_next = icell_reg;
		for (int i = 0; i < ICELL_W; i++) begin
			if (icell_store_mode[i]) begin
				if (lclk_rise)
					icell_next[i] = pin_s[i];
			end else if (pin_s[25]) begin
				icell_next[i] = pin_s[i];
			end
		end
	end
	// Register file storage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_a_reg <= DATA_RST;
			out_b_reg <= DATA_RST;
			out_c_reg <= DATA_RST;
			out_d_reg <= 3'h0;
			blk_a_reg <= BLOCK_RST;
			blk_b_reg <= BLOCK_RST;
			blk_c_reg <= BLOCK_RST;
			cell_reg <= 16'h0000;
			icell_reg <= 24'h000000;
			rdata_reg <= UNMAPPED_RD;
		end else if (clk_en) begin
			out_a_reg <= out_a_next;
			out_b_reg <= out_b_next;
			out_c_reg <= out_c_next;
			out_d_reg <= out_d_next;
			blk_a_reg <= blk_a_next;
			blk_b_reg <= blk_b_next;
			blk_c_reg <= blk_c_next;
			cell_reg <= cell_next;
			icell_reg <= icell_next;
			rdata_reg <= rdata_next;
		end
	end
	assign bus_rdata = rdata_reg;
	// input cells go to the logic input bus
	assign input_logic_cell = icell_reg;
	assign output_logic_cell = cell_reg;

	// ****************************************
	// Pin drivers
	// ****************************************
	logic [26:0] pout_reg, pout_next, poe_reg, poe_next;
	logic [13:0] misc_reg, misc_next;
	logic [1:0] d2;
	// Pin values and enables
	always_comb begin
		pout_next = 27'h0000000;
		poe_next = 27'h0000000;
		d2 = 2'b00;
		for (int i = 0; i < DATA_W; i++) begin
			// value driven when direction or term set
			// high A/B pins open drain, low pins slew
			// first group on A, B either, second on C
			d2 = drv(cell_on_a[i] ? cell_reg[i] : out_a_reg[i], dir_a[i] | oe_term_a[i],
				(i >= OD_LOW_BIT) && drive_a[i]);
			{pout_next[i], poe_next[i]} = d2;
			d2 = drv(cell_on_b[i] ? cell_b_view[i] : out_b_reg[i], dir_b[i] | oe_term_b[i],
				(i >= OD_LOW_BIT) && drive_b[i]);
			{pout_next[8+i], poe_next[8+i]} = d2;
			// port C has no address output path
			d2 = drv(cell_on_c[i] ? cell_reg[8+i] : out_c_reg[i], dir_c[i] | oe_term_c[i],
				drive_c[i]);
			{pout_next[16+i], poe_next[16+i]} = d2;
		end
		// port A returns read data as the data bus
		if (data_port_mode) begin
			// Same edge as bus_rdata, so the pins never show stale data
			pout_next[7:0] = rdata_next;
			poe_next[7:0] = {8{io_register_space && bus_rd && !csi_block}};
		// buffer mode only exists for port A
		end else if (periph_mode) begin
			pout_next[7:0] = bus_wdata;
			poe_next[7:0] = {8{periph_sel && bus_wr}};
		end
		// top pin of C taken as byte enable input
		if (dbe_select)
			poe_next[23] = 1'b0;
		if (battery_on_select) begin
			pout_next[20] = pin_s[27];
			poe_next[20] = 1'b1;
		end
		for (int j = 0; j < PORT_D_W; j++) begin
			// one term per select, own polarity
			// enable from term or direction bit
			if (ecs_enable[j]) begin
				pout_next[24+j] = ecs_term[j] ^ ecs_active_low[j];
				poe_next[24+j] = ecs_oe_from_term[j] ? ecs_oe_term[j] : dir_d[j];
			end else begin
				pout_next[24+j] = out_d_reg[j];
				poe_next[24+j] = dir_d[j];
			end
			if (d_dedicated[j])
				poe_next[24+j] = 1'b0;
		end
		// port D inputs straight to the logic
		// chip select gates the memories and blocks register reads and writes
		misc_next = {pin_s[26:24], pin_s[24] & d_dedicated[0],
			dbe_select ? pin_s[23] : 1'b1, csi_block, drive_a[3:0], drive_b[3:0]};
	end
	// Pin output registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pout_reg <= 27'h0000000;
			poe_reg <= 27'h0000000;
			misc_reg <= 14'h0000;
		end else if (clk_en) begin
			pout_reg <= pout_next;
			poe_reg <= poe_next;
			misc_reg <= misc_next;
		end
	end
	// driver status comes from these enables
	assign {port_d_out, port_c_out, port_b_out, port_a_out} = pout_reg;
	assign {port_d_oe, port_c_oe, port_b_oe, port_a_oe} = poe_reg;
	assign {d_direct, address_strobe_in, data_byte_enable, memories_disable} = misc_reg[13:8];
	assign fast_slew_a = misc_reg[7:4];
	assign fast_slew_b = misc_reg[3:0];
	logic [2:0] slew_d_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			slew_d_reg <= 3'h0;
		else if (clk_en)
			slew_d_reg <= drive_d;
	end
	assign fast_slew_d = slew_d_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_block_holds_cell: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_hit(acc_wr, bus_addr, OCELL_A) && !lclk_rise) |=>
		(((cell_reg[7:0] ^ $past(cell_reg[7:0])) & $past(blk_a_reg)) == 8'h00))
		else $error("blocked cell bit changed on bus write");
	a_cell_read_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_hit(acc_rd, bus_addr, OCELL_C) |=> (bus_rdata == $past(cell_reg[15:8])))
		else $error("cell read does not show cell outputs");
	a_icell_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && icell_store_mode[0] && lclk_rise) |=> (icell_reg[0] == $past(pin_s[0])))
		else $error("input cell missed store");
	a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_hit(acc_rd, bus_addr, DRV_EN_B) |=> (bus_rdata == $past(port_b_oe)))
		else $error("driver status mismatch");
	a_ecs_polarity: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && ecs_enable[1]) |=> (port_d_out[1] == $past(ecs_term[1] ^ ecs_active_low[1])))
		else $error("external select polarity wrong");
	a_csi_ignores: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && csi_block && bus_wr && io_register_space) |=> $stable(out_a_reg) && $stable(blk_b_reg))
		else $error("register written while deselected");
	a_ro_write_none: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_hit(acc_wr, bus_addr, PIN_IN_A) && !lclk_rise) |=>
		$stable(out_a_reg) && $stable(cell_reg) && $stable(blk_a_reg))
		else $error("read-only write had an effect");
	a_pin_in_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_hit(acc_rd, bus_addr, PIN_IN_B) |=> (bus_rdata == $past(pin_s[15:8])))
		else $error("pin input read mismatch");
	a_out_driven: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && dir_a[0] && !cell_on_a[0] && !data_port_mode && !periph_mode) |=>
		(port_a_oe[0] && port_a_out[0] == $past(out_a_reg[0])))
		else $error("output value not driven");
endmodule // io_port_macrocell_access
`default_nettype wire

/* File: testbench/pin_partner.sv */
// Pin-side model: resolves every port pin from the block's drive and the outside level.
// Assumes the bench supplies the outside levels, chip select included, on d_ext.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe,
	input wire logic [7:0] port_c_out,
	input wire logic [7:0] port_c_oe,
	input wire logic [2:0] port_d_out,
	input wire logic [2:0] port_d_oe,
	input wire logic [7:0] a_ext,
	input wire logic [7:0] b_ext,
	input wire logic [7:0] c_ext,
	input wire logic [2:0] d_ext,
	output logic [7:0] port_a_in,
	output logic [7:0] port_b_in,
	output logic [7:0] port_c_in,
	output logic [2:0] port_d_in
);
	// ****************************************
	// Wire resolution
	// ****************************************
	// Driven bits show the block, released bits the outside level
	assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & a_ext);
	assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & b_ext);
	assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & c_ext);
	assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & d_ext);
endmodule // pin_partner
`default_nettype wire

/* File: testbench/io_port_macrocell_access_tb.sv */
// Self-checking bench: register reads noted in a queue, compared when read data lands.
// Assumes the pin_partner model and the io_port_pkg constants.
`timescale 1ns/1ps
`default_nettype none
module io_port_macrocell_access_tb;
	import io_port_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, io_register_space = 1'b0;
	logic bus_wr = 1'b0, bus_rd = 1'b0, b_uses_second_group = 1'b0;
	logic [4:0] bus_addr = 5'h00;
	logic [7:0] bus_wdata = 8'h00, a_ext = 8'h00, b_ext = 8'h00, c_ext = 8'h00;
	logic [7:0] dir_a = 8'h00, dir_b = 8'h00, dir_c = 8'h00, drive_a = 8'h00;
	logic [7:0] drive_b = 8'h00, drive_c = 8'h00, oe_term_a = 8'h00, oe_term_b = 8'h00;
	logic [7:0] oe_term_c = 8'h00, cell_on_a = 8'h00, cell_on_b = 8'h00, cell_on_c = 8'h00;
	logic [2:0] dir_d = 3'h0, drive_d = 3'h0, d_ext = 3'h0, d_dedicated = 3'h0;
	logic [2:0] ecs_enable = 3'h0, ecs_term = 3'h0, ecs_active_low = 3'h0;
	logic [2:0] ecs_oe_term = 3'h0, ecs_oe_from_term = 3'h0;
	logic [15:0] cell_d_in = 16'h0000;
	logic [23:0] icell_store_mode = 24'h000000;
	logic data_port_mode = 1'b0, periph_mode = 1'b0, periph_sel = 1'b0, dbe_select = 1'b0;
	logic battery_on_select = 1'b0, battery_low = 1'b0;
	logic [7:0] bus_rdata, port_a_out, port_a_oe, port_b_out, port_b_oe, port_c_out, port_c_oe;
	logic [7:0] port_a_in, port_b_in, port_c_in, v1, v2, v3;
	logic [2:0] port_d_out, port_d_oe, port_d_in, d_direct;
	logic [3:0] fast_slew_a;
	logic [15:0] output_logic_cell;
	logic [23:0] input_logic_cell;
	logic memories_disable, data_byte_enable, rd_q = 1'b0;
	logic [7:0] exp_q[$];
	int bad_count = 0, n_checks = 0, cycles = 0;

	// ****************************************
	// Clock, instances, checking
	// ****************************************
	always #50 ref_clk = ~ref_clk;

	io_port_macrocell_access dut_u (.ref_clk, .rst_n, .clk_en, .io_register_space, .bus_addr,
		.bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .port_a_in, .port_a_out, .port_a_oe,
		.port_b_in, .port_b_out, .port_b_oe, .port_c_in, .port_c_out, .port_c_oe, .port_d_in,
		.port_d_out, .port_d_oe, .dir_a, .dir_b, .dir_c, .dir_d, .drive_a, .drive_b, .drive_c,
		.drive_d, .oe_term_a, .oe_term_b, .oe_term_c, .cell_on_a, .cell_on_b, .cell_on_c,
		.b_uses_second_group, .cell_d_in, .icell_store_mode, .data_port_mode, .periph_mode,
		.periph_sel, .dbe_select, .battery_on_select, .battery_low, .ecs_enable, .ecs_term,
		.ecs_active_low, .ecs_oe_term, .ecs_oe_from_term, .d_dedicated, .input_logic_cell,
		.d_direct, .output_logic_cell, .address_strobe_in(), .data_byte_enable,
		.memories_disable, .fast_slew_a, .fast_slew_b(), .fast_slew_d());

	pin_partner pins_u (.port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .port_c_out,
		.port_c_oe, .port_d_out, .port_d_oe, .a_ext, .b_ext, .c_ext, .d_ext, .port_a_in,
		.port_b_in, .port_c_in, .port_d_in);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (exp_q.size() != 0)
			bad_count++;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Read data lands on the same edge that takes the read
	always @(posedge ref_clk) begin
		rd_q <= bus_rd & io_register_space;
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end

	// Oldest note against the landed read data
	always @(negedge ref_clk) begin
		if (rd_q)
			chk(16'(bus_rdata), 16'(exp_q.pop_front()));
	end

	// One register access, held for exactly one taken edge
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		io_register_space = 1'b1;
		bus_wr = w;
		bus_rd = ~w;
		bus_addr = a;
		bus_wdata = d;
		@(negedge ref_clk);
		io_register_space = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(40));
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		// Block masks start clear
		for (int i = 0; i < 3; i++)
			rd(OBLOCK_A + 5'(i), BLOCK_RST);
		// Output value drives the pins and reads back
		v1 = 8'($urandom);
		dir_a = 8'hff;
		acc(1'b1, PIN_OUT_A, v1);
		rd(PIN_OUT_A, v1);
		chk(16'(port_a_out), 16'(v1));
		chk(16'(port_a_oe), 16'hff);
		rd(DRV_EN_A, 8'hff);
		// Direction or product term enables the driver
		dir_a = 8'h0f;
		oe_term_a = 8'h30;
		repeat (3) @(negedge ref_clk);
		rd(DRV_EN_A, 8'h3f);
		// Live pin levels, writes to read-only places ignored
		b_ext = 8'($urandom);
		repeat (4) @(negedge ref_clk);
		acc(1'b1, PIN_IN_B, ~b_ext);
		rd(PIN_IN_B, b_ext);
		acc(1'b1, PIN_IN_A, 8'hff);
		rd(PIN_OUT_A, v1);
		acc(1'b1, DRV_EN_B, 8'hff);
		rd(DRV_EN_B, 8'h00);
		acc(1'b1, 5'h1f, 8'haa);
		rd(5'h1f, UNMAPPED_RD);
		acc(1'b1, PIN_OUT_D, 8'hff);
		rd(PIN_OUT_D, 8'h07);
		// Output cells load by bus, follow routing and mask
		v2 = 8'($urandom);
		v3 = 8'($urandom);
		acc(1'b1, OCELL_A, v2);
		rd(OCELL_A, v2);
		rd(OCELL_B, v2);
		chk(output_logic_cell & 16'h00ff, 16'(v2));
		b_uses_second_group = 1'b1;
		acc(1'b1, OCELL_C, v3);
		rd(OCELL_B, v3);
		acc(1'b1, OBLOCK_A, 8'h0f);
		rd(OBLOCK_A, 8'h0f);
		acc(1'b1, OCELL_A, ~v2);
		rd(OCELL_A, {~v2[7:4], v2[3:0]});
		acc(1'b1, OBLOCK_A, 8'h00);
		// Logic clock loads output cells and stores input cells
		dir_a = 8'h00;
		oe_term_a = 8'h00;
		a_ext = 8'($urandom);
		cell_d_in = 16'($urandom);
		icell_store_mode = 24'hffffff;
		d_dedicated = 3'b010;
		repeat (4) @(negedge ref_clk);
		d_ext = 3'b010;
		repeat (6) @(negedge ref_clk);
		chk(output_logic_cell, cell_d_in);
		chk(16'(input_logic_cell[7:0]), 16'(a_ext));
		v1 = a_ext;
		a_ext = ~a_ext;
		repeat (6) @(negedge ref_clk);
		rd(ICELL_A, v1);
		// Chip select high shuts the register space
		acc(1'b1, PIN_OUT_A, v3);
		d_dedicated = 3'b110;
		d_ext = 3'b100;
		repeat (4) @(negedge ref_clk);
		chk(16'(memories_disable), 16'h1);
		// Logic clock still loads cells while deselected
		cell_d_in = ~cell_d_in;
		d_ext = 3'b110;
		repeat (6) @(negedge ref_clk);
		chk(output_logic_cell, cell_d_in);
		acc(1'b1, PIN_OUT_A, ~v3);
		d_ext = 3'b000;
		repeat (4) @(negedge ref_clk);
		chk(16'(memories_disable), 16'h0);
		rd(PIN_OUT_A, v3);
		// Clock enable low freezes the register file
		clk_en = 1'b0;
		acc(1'b1, PIN_OUT_A, ~v3);
		clk_en = 1'b1;
		rd(PIN_OUT_A, v3);
		// Open drain on high pins, slew select on low pins
		v1 = 8'($urandom);
		d_dedicated = 3'b000;
		d_ext = 3'b000;
		dir_a = 8'hff;
		drive_a = 8'hff;
		acc(1'b1, PIN_OUT_A, v1);
		repeat (2) @(negedge ref_clk);
		chk(16'(port_a_out), 16'({4'h0, v1[3:0]}));
		chk(16'(port_a_oe), 16'({~v1[7:4], 4'hf}));
		chk(16'(fast_slew_a), 16'h000f);
		rd(DRV_EN_A, {~v1[7:4], 4'hf});
		// Port A as data bus, then as peripheral buffer
		drive_a = 8'h00;
		data_port_mode = 1'b1;
		rd(PIN_OUT_A, v1);
		chk(16'(port_a_out), 16'(v1));
		chk(16'(port_a_oe), 16'h00ff);
		data_port_mode = 1'b0;
		periph_mode = 1'b1;
		periph_sel = 1'b1;
		v2 = 8'($urandom);
		acc(1'b1, 5'h1f, v2);
		chk(16'(port_a_out), 16'(v2));
		chk(16'(port_a_oe), 16'h00ff);
		chk(16'(port_b_oe), 16'h0000);
		periph_mode = 1'b0;
		periph_sel = 1'b0;
		dir_a = 8'h00;
		// Port C special pins, external selects, direct port D inputs
		c_ext = 8'($urandom);
		battery_on_select = 1'b1;
		battery_low = 1'b1;
		dbe_select = 1'b1;
		dir_c = 8'hff;
		ecs_enable = 3'h7;
		ecs_term = 3'($urandom);
		ecs_active_low = 3'($urandom);
		ecs_oe_from_term = 3'h5;
		ecs_oe_term = 3'h1;
		dir_d = 3'h2;
		d_ext = 3'($urandom);
		repeat (5) @(negedge ref_clk);
		chk(16'(data_byte_enable), 16'(c_ext[7]));
		chk(16'(port_c_oe[7]), 16'h0000);
		chk(16'(port_c_out[4]), 16'h0001);
		chk(16'(port_c_oe[4]), 16'h0001);
		chk(16'(port_d_out), 16'(ecs_term ^ ecs_active_low));
		chk(16'(port_d_oe), 16'h0003);
		chk(16'(d_direct), 16'(port_d_in));
		repeat (2) @(negedge ref_clk);
		conclude();
	end
endmodule // io_port_macrocell_access_tb
`default_nettype wire
